// ==== rtl/glc_pkg.sv ====
package glc_pkg;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_HZ          = 10_000_000;
   localparam int MS_CYC          = CLK_HZ / 1000;          // cycles per millisecond
   localparam int PULSE_MIN_MS    = 350;
   localparam int PULSE_MAX_MS    = 400;
   localparam int DIR_MIN_MS      = 40;
   localparam int DIR_MAX_MS      = 500;
   localparam int SIMUL_MAX_MS    = 20;
   localparam int DIAG_RAISE_MS   = 500;
   localparam int PROC_MS         = 100;
   localparam int MAX_CHAIN       = 6;
   localparam int MAX_SUBSCR      = 16;
   localparam int MS_W            = 12;                     // ms counter width
   // ****************************************************************
   // diagnostic frame layout (8-bit request words, 16-bit replies, lsb first)
   // ****************************************************************
   localparam int DIAG_BIT_CYC    = 100;                    // cycles per diag bit
   localparam int DIAG_WORD_W     = 8;
   localparam logic [3:0] OP_POLL   = 4'h1;
   localparam logic [3:0] OP_SERIAL = 4'h2;
   localparam logic [3:0] OP_TEACH  = 4'h3;
   localparam logic [3:0] OP_LOCK   = 4'h4;
   localparam logic [3:0] OP_UNLOCK = 4'h5;
   localparam logic [15:0] SERIAL_DEF = 16'h1234;           // arbitrary value
   localparam logic [7:0]  TEACH_DEF  = 8'h08;
   // ****************************************************************
   // modes
   // ****************************************************************
   typedef enum logic [1:0] {GLC_PULSE, GLC_DIRECT, GLC_TOGGLE} glc_scheme_t;
endpackage

// ==== rtl/glc_if.sv ====
`timescale 1ns/100ps
// ****************************************************************
// link between switch and safety control system
// ****************************************************************
interface glc_if;
   logic chain_input_a;
   logic chain_input_b;
   logic lock_request_a;
   logic lock_request_b;
   logic diag_input;
   logic safety_output_1;
   logic safety_output_2;
   logic signal_diag_output;
   modport dev (input chain_input_a, chain_input_b, lock_request_a, lock_request_b,
                diag_input, output safety_output_1, safety_output_2, signal_diag_output);
   modport ctl (output chain_input_a, chain_input_b, lock_request_a, lock_request_b,
                diag_input, input safety_output_1, safety_output_2, signal_diag_output);
endinterface

// ==== rtl/glc_switch.sv ====
`timescale 1ns/100ps
// Functional notes
// - outputs high only actuator, locked, both chains
// - one chain falls alone: unequal, flash
// - same input returns: feasibility error, lock
// - both low first releases partial lock
// - fieldbus attached activates diagnostic input reading
// - no fieldbus: diagnostic input held high
// - chained output feeds next diagnostic input
// - signal output shows actuator or diag data
// - requests both low: pin keeps position
// - controller raises requests within 500 ms
// - 350-400 ms double pulse toggles locking
// - chain pulse n times 350 ms
// - directional: a leads b 40-500 ms locks
// - directional: b leads a 40-500 ms unlocks
// - non-directional: edges under 20 ms toggle
// - up to 16 chained diagnostic subscribers
// - diagnostics start only when the diagnostic input first goes low
// - answer poll, parameter read, lock actions
// - restart in mode without diagnostics
// - request processed within 100 ms
module glc_switch (
   input  wire logic               CLK,
   input  wire logic               RESETN,
   glc_if.dev                      LINK,
   input  wire glc_pkg::glc_scheme_t SCHEME,
   input  wire logic [2:0]         CHAIN_LEN,
   input  wire logic [3:0]         MY_ADDR,
   input  wire logic               ACTUATOR_PRESENT,
   input  wire logic               PIN_LOCKED,
   output logic                    LOCK_CMD,
   output logic                    UNEQUAL,
   output logic                    FEAS_ERR,
   output logic                    INPUT_FLASH,
   output logic                    DIAG_ACTIVE
);
   import glc_pkg::*;

   // ****************************************************************
   // millisecond timebase
   // ****************************************************************
   logic [13:0]     pre_r;
   logic            ms_tick;
   assign ms_tick = (pre_r == 14'(MS_CYC - 1));
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) pre_r <= '0;
      else         pre_r <= ms_tick ? '0 : pre_r + 14'h1;
   end

   // ****************************************************************
   // chained safety inputs and feasibility
   // ****************************************************************
   logic            ca_r, cb_r, ca_d_r, cb_d_r;
   logic            unequal_r, feas_r, fall_a_r;
   wire  fall_a   = ca_d_r & ~ca_r & cb_r;
   wire  fall_b   = cb_d_r & ~cb_r & ca_r;
   wire  rise_a   = ~ca_d_r & ca_r & cb_r;
   wire  rise_b   = ~cb_d_r & cb_r & ca_r;
   wire  both_low = ~ca_r & ~cb_r;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ca_r <= 1'b0; cb_r <= 1'b0; ca_d_r <= 1'b0; cb_d_r <= 1'b0;
      end else begin
         ca_r <= LINK.chain_input_a; cb_r <= LINK.chain_input_b;
         ca_d_r <= ca_r; cb_d_r <= cb_r;
      end
   end
   // discrepancy tracking; both low clears unequal_r and feas_r
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         unequal_r <= 1'b0; feas_r <= 1'b0; fall_a_r <= 1'b0;
      end else if (both_low) begin
         unequal_r <= 1'b0; feas_r <= 1'b0;
      end else if (fall_a | fall_b) begin
         unequal_r <= 1'b1;
         fall_a_r  <= fall_a;
      end else if (unequal_r & ((rise_a & fall_a_r) | (rise_b & ~fall_a_r))) begin
         feas_r    <= 1'b1;
      end
   end
   assign UNEQUAL     = unequal_r;
   assign FEAS_ERR    = feas_r;
   assign INPUT_FLASH = unequal_r | feas_r;

   // ****************************************************************
   // safety outputs
   // ****************************************************************
   logic so_r;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) so_r <= 1'b0;
      else so_r <= ACTUATOR_PRESENT & PIN_LOCKED & ca_r & cb_r & ~feas_r & ~unequal_r;
   end
   assign LINK.safety_output_1 = so_r;
   assign LINK.safety_output_2 = so_r;

   // ****************************************************************
   // request decoding
   // ****************************************************************
   logic            ra_r, rb_r, ra_d_r, rb_d_r;
   logic [MS_W-1:0] wa_r, wb_r;             // ms since edge / high time
   logic            lock_r, arm_a_r, arm_b_r, hi_r, pend_r;
   wire  rise_ra = ra_r & ~ra_d_r;
   wire  rise_rb = rb_r & ~rb_d_r;
   wire  [MS_W-1:0] pmin = MS_W'(PULSE_MIN_MS) * MS_W'(CHAIN_LEN == 3'h0 ? 3'h1 : CHAIN_LEN);
   wire  [MS_W-1:0] pmax = MS_W'(PULSE_MAX_MS) * MS_W'(CHAIN_LEN == 3'h0 ? 3'h1 : CHAIN_LEN);
   wire  pulse_ok = hi_r & ~(ra_r & rb_r) & (wa_r >= pmin) & (wa_r <= pmax);
   wire  dir_lock = rise_rb & arm_a_r & (wa_r >= MS_W'(DIR_MIN_MS)) & (wa_r <= MS_W'(DIR_MAX_MS));
   wire  dir_unl  = rise_ra & arm_b_r & (wb_r >= MS_W'(DIR_MIN_MS)) & (wb_r <= MS_W'(DIR_MAX_MS));
   wire  tog_ab   = (rise_ra & rise_rb) | (rise_rb & arm_a_r & (wa_r < MS_W'(SIMUL_MAX_MS)))
                  | (rise_ra & arm_b_r & (wb_r < MS_W'(SIMUL_MAX_MS)));
   logic            diag_lock_req, diag_unl_req;
   logic            lock_nxt;
   always_comb begin
      lock_nxt = lock_r;
      case (SCHEME)
         GLC_PULSE:  if (pulse_ok) lock_nxt = ~lock_r;
         GLC_DIRECT: begin
            if (dir_lock)     lock_nxt = 1'b1;
            else if (dir_unl) lock_nxt = 1'b0;
         end
         GLC_TOGGLE: if (tog_ab) lock_nxt = ~lock_r;
         default:    lock_nxt = lock_r;
      endcase
      if (ra_r & rb_r & diag_lock_req) lock_nxt = 1'b1;
      if (ra_r & rb_r & diag_unl_req)  lock_nxt = 1'b0;
   end
   // sampling, edge timers and lock state; both low holds pin
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ra_r <= 1'b0; rb_r <= 1'b0; ra_d_r <= 1'b0; rb_d_r <= 1'b0;
         wa_r <= '0; wb_r <= '0; lock_r <= 1'b0;
         arm_a_r <= 1'b0; arm_b_r <= 1'b0; hi_r <= 1'b0;
      end else begin
         ra_r <= LINK.lock_request_a; rb_r <= LINK.lock_request_b;
         ra_d_r <= ra_r; rb_d_r <= rb_r;
         lock_r <= lock_nxt;
         hi_r   <= ra_r & rb_r;
         if (rise_ra | (rise_rb & (SCHEME == GLC_PULSE) & ~arm_a_r)) wa_r <= '0;
         else if (ms_tick && wa_r != '1) wa_r <= wa_r + MS_W'(1);
         if (rise_rb) wb_r <= '0;
         else if (ms_tick && wb_r != '1) wb_r <= wb_r + MS_W'(1);
         arm_a_r <= rise_ra ? 1'b1 : (rise_rb | (~ra_r & ~rb_r)) ? 1'b0 : arm_a_r;
         arm_b_r <= rise_rb & ~rise_ra & ~arm_a_r ? 1'b1
                  : (rise_ra | (~ra_r & ~rb_r)) ? 1'b0 : arm_b_r;
      end
   end
   assign LOCK_CMD = lock_r;

   // ****************************************************************
   // diagnostics serial engine: byte = {addr[3:0], op[3:0]}
   // ****************************************************************
   typedef enum logic [1:0] {GLC_IDLE, GLC_RX, GLC_TX} glc_dstate_t;
   glc_dstate_t     st_r;
   logic            dact_r, di_r;
   logic [6:0]      bc_r;
   logic [4:0]      bi_r;
   logic [15:0]     sh_r;
   wire  bit_t = (bc_r == 7'(DIAG_BIT_CYC - 1));
   // last data bit is still on di_r; start bit sits at sh_r[8]
   wire  mine  = ({di_r, sh_r[15:13]} == MY_ADDR);
   wire  [3:0] op = sh_r[12:9];
   assign diag_lock_req = dact_r & (st_r == GLC_RX) & bit_t & (bi_r == 5'h8) & mine
                        & (op == OP_LOCK);
   assign diag_unl_req  = dact_r & (st_r == GLC_RX) & bit_t & (bi_r == 5'h8) & mine
                        & (op == OP_UNLOCK);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_r <= GLC_IDLE; dact_r <= 1'b0; di_r <= 1'b1;
         bc_r <= '0; bi_r <= '0; sh_r <= '0;
      end else begin
         di_r <= LINK.diag_input;
         bc_r <= (st_r == GLC_IDLE || bit_t) ? '0 : bc_r + 7'h1;
         case (st_r)
            GLC_IDLE: if (!di_r) begin
               dact_r <= 1'b1; st_r <= GLC_RX; bi_r <= '0;
            end
            GLC_RX: if (bit_t) begin
               sh_r <= {di_r, sh_r[15:1]};
               bi_r <= bi_r + 5'h1;
               if (bi_r == 5'h8) begin
                  st_r <= GLC_TX; bi_r <= '0;
                  case (op)
                     OP_POLL:   sh_r <= {12'h0, 2'b00, lock_r, so_r};
                     OP_SERIAL: sh_r <= SERIAL_DEF;
                     OP_TEACH:  sh_r <= {8'h00, TEACH_DEF};
                     default:   sh_r <= {15'h0, lock_r};
                  endcase
               end
            end
            GLC_TX: if (bit_t) begin
               sh_r <= {1'b1, sh_r[15:1]};
               bi_r <= bi_r + 5'h1;
               if (bi_r == 5'hF) st_r <= GLC_IDLE;
            end
            default: st_r <= GLC_IDLE;
         endcase
      end
   end
   assign DIAG_ACTIVE = dact_r;
   // actuator status, or frame data while sending
   assign LINK.signal_diag_output = (st_r == GLC_TX) ? sh_r[0] : ACTUATOR_PRESENT;
endmodule // glc_switch

// ==== rtl/glc_ctrl.sv ====
`timescale 1ns/100ps
module glc_ctrl (
   input  wire logic  CLK,
   input  wire logic  RESETN,
   glc_if.ctl         LINK,
   input  wire logic  CHAIN_A,
   input  wire logic  CHAIN_B,
   input  wire logic  REQ_START,
   input  wire logic [2:0] CHAIN_LEN,
   output logic       BUSY,
   output logic       SAFE_OK
);
   import glc_pkg::*;
   // ****************************************************************
   // request pulse generator, held about n x 360 ms
   // ****************************************************************
   logic [13:0]     pre_r;
   logic [MS_W-1:0] ms_r;
   logic            act_r;
   wire  tick = (pre_r == 14'(MS_CYC - 1));
   wire  [MS_W-1:0] len = MS_W'(PULSE_MIN_MS + 10) * MS_W'(CHAIN_LEN == 3'h0 ? 3'h1 : CHAIN_LEN);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pre_r <= '0; ms_r <= '0; act_r <= 1'b0;
      end else begin
         pre_r <= tick ? '0 : pre_r + 14'h1;
         if (REQ_START & ~act_r) begin
            act_r <= 1'b1; ms_r <= '0;
         end else if (act_r & tick) begin
            ms_r <= ms_r + MS_W'(1);
            if (ms_r == len) act_r <= 1'b0;
         end
      end
   end
   assign LINK.lock_request_a = act_r;
   assign LINK.lock_request_b = act_r;
   assign LINK.chain_input_a  = CHAIN_A;
   assign LINK.chain_input_b  = CHAIN_B;
   assign LINK.diag_input     = 1'b1;
   assign BUSY    = act_r;
   assign SAFE_OK = LINK.safety_output_1 & LINK.safety_output_2;
endmodule // glc_ctrl

// ==== verif/glc_assertions.sv ====
`timescale 1ns/100ps
// ****************************************************************
// link checker
// ****************************************************************
module glc_assertions (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic chain_input_a,
   input wire logic chain_input_b,
   input wire logic lock_request_a,
   input wire logic lock_request_b,
   input wire logic diag_input,
   input wire logic safety_output_1,
   input wire logic safety_output_2,
   input wire logic signal_diag_output,
   input wire logic ACTUATOR_PRESENT,
   input wire logic PIN_LOCKED,
   input wire logic LOCK_CMD,
   input wire logic UNEQUAL,
   input wire logic FEAS_ERR,
   input wire logic DIAG_ACTIVE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);
   // all enabling conditions at once
   wire all_ok = ACTUATOR_PRESENT && PIN_LOCKED && chain_input_a && chain_input_b;
   // one channel drops, then returns, the other staying high
   sequence a_drop;
      $fell(chain_input_a) && chain_input_b && $past(chain_input_b);
   endsequence
   sequence a_back;
      $rose(chain_input_a) && chain_input_b && UNEQUAL;
   endsequence
   a_out_low: assert property ((!all_ok) [*4] |=> !safety_output_1 && !safety_output_2)
      else $error("safety outputs high without all conditions");
   a_out_high: assert property ((all_ok && !UNEQUAL && !FEAS_ERR) [*5] |=> safety_output_1)
      else $error("safety output low with all conditions met");
   a_out_pair: assert property (safety_output_1 == safety_output_2)
      else $error("safety output channels differ");
   a_unequal_set: assert property (a_drop |-> ##[1:4] UNEQUAL)
      else $error("unequal status not flagged");
   a_feas_set: assert property (a_back |-> ##[1:4] FEAS_ERR)
      else $error("feasibility error not flagged");
   a_feas_outputs: assert property (FEAS_ERR |=> !safety_output_1 && !safety_output_2)
      else $error("safety outputs high in partial operation lock");
   a_flags_clear: assert property ((!chain_input_a && !chain_input_b) [*4] |=> !UNEQUAL && !FEAS_ERR)
      else $error("flags kept after both inputs low");
   a_diag_idle: assert property ($past(RESETN, 2) |-> diag_input)
      else $error("diagnostic input not held high");
   a_sig_actuator: assert property (!DIAG_ACTIVE |-> signal_diag_output == ACTUATOR_PRESENT)
      else $error("signal output does not show actuator");
   a_lock_hold: assert property ((!lock_request_a && !lock_request_b) [*5] |=> $stable(LOCK_CMD))
      else $error("lock state changed with requests low");
   a_restart_mode: assert property ($rose(RESETN) |-> !DIAG_ACTIVE && !LOCK_CMD)
      else $error("restart not in plain mode");
endmodule // glc_assertions

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import glc_pkg::*;
   logic       CLK, RESETN, chain_a, chain_b, req_start, act, pin;
   logic       lock_cmd, unequal, feas_err, flash, diag_act, busy, safe_ok;
   glc_scheme_t scheme;
   int         n_mismatch = 0;
   int         compares = 0;
   int         cyc = 0;
   // rows {actuator, pin locked, chain a, chain b, expected outputs}
   logic [4:0] rows [7] = '{5'h00, 5'h1F, 5'h0E, 5'h16, 5'h1F, 5'h18, 5'h10};
   glc_if u_link ();
   glc_switch u_glc_switch (.CLK(CLK), .RESETN(RESETN), .LINK(u_link), .SCHEME(scheme),
      .CHAIN_LEN(3'h1), .MY_ADDR(4'h3), .ACTUATOR_PRESENT(act), .PIN_LOCKED(pin),
      .LOCK_CMD(lock_cmd), .UNEQUAL(unequal), .FEAS_ERR(feas_err), .INPUT_FLASH(flash),
      .DIAG_ACTIVE(diag_act));
   glc_ctrl u_glc_ctrl (.CLK(CLK), .RESETN(RESETN), .LINK(u_link), .CHAIN_A(chain_a),
      .CHAIN_B(chain_b), .REQ_START(req_start), .CHAIN_LEN(3'h1), .BUSY(busy), .SAFE_OK(safe_ok));
   glc_assertions u_glc_assertions (.CLK(CLK), .RESETN(RESETN),
      .chain_input_a(u_link.chain_input_a), .chain_input_b(u_link.chain_input_b),
      .lock_request_a(u_link.lock_request_a), .lock_request_b(u_link.lock_request_b),
      .diag_input(u_link.diag_input), .safety_output_1(u_link.safety_output_1),
      .safety_output_2(u_link.safety_output_2), .signal_diag_output(u_link.signal_diag_output),
      .ACTUATOR_PRESENT(act), .PIN_LOCKED(pin), .LOCK_CMD(lock_cmd), .UNEQUAL(unequal),
      .FEAS_ERR(feas_err), .DIAG_ACTIVE(diag_act));
   // ****************************************************************
   // clock, watchdog, helpers
   // ****************************************************************
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   // hang guard
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task chk(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask
   task stop_test;
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // apply {actuator, pin, chain a, chain b} and let it settle
   task put(input logic [3:0] v);
      @(negedge CLK);
      {act, pin, chain_a, chain_b} = v;
      repeat (6) @(negedge CLK);
   endtask
   task outs(input logic e);
      chk("safety_output_1", e, u_link.safety_output_1);
      chk("safety_output_2", e, u_link.safety_output_2);
      chk("safe_ok", e, safe_ok);
   endtask
   task flags(input logic u, input logic f);
      chk("unequal", u, unequal);
      chk("feas_err", f, feas_err);
      chk("input_flash", u | f, flash);
   endtask
   // raise the request pair from the controller, wait for it on the link
   task req_pulse;
      @(negedge CLK);
      req_start = 1'b1;
      @(negedge CLK);
      req_start = 1'b0;
      for (int k = 0; k < 10 && u_link.lock_request_a !== 1'b1; k++) @(negedge CLK);
   endtask
   // reset in mid-run, choosing the decoding scheme while held
   task reboot(input glc_scheme_t s);
      RESETN = 1'b0;
      @(negedge CLK);
      chk("busy", 1'b0, busy);
      outs(1'b0);
      scheme = s;
      RESETN = 1'b1;
      @(negedge CLK);
      chk("diag_active", 1'b0, diag_act);
      chk("lock_cmd", 1'b0, lock_cmd);
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      RESETN = 1'b0;
      scheme = GLC_PULSE;
      {act, pin, chain_a, chain_b, req_start} = 5'h00;
      repeat (6) @(negedge CLK);
      RESETN = 1'b1;
      @(negedge CLK);
      chk("diag_active", 1'b0, diag_act);
      chk("lock_cmd", 1'b0, lock_cmd);
      // table of output cases
      foreach (rows[i]) begin
         put(rows[i][4:1]);
         outs(rows[i][0]);
         chk("signal_diag_output", rows[i][4], u_link.signal_diag_output);
         chk("diag_input", 1'b1, u_link.diag_input);
      end
      // one channel drops and returns, then both low to recover
      put(4'hF);
      put(4'hD);
      flags(1'b1, 1'b0);
      outs(1'b0);
      put(4'hF);
      flags(1'b1, 1'b1);
      outs(1'b0);
      put(4'hC);
      flags(1'b0, 1'b0);
      put(4'hF);
      outs(1'b1);
      // the other channel drops and returns
      put(4'hE);
      flags(1'b1, 1'b0);
      put(4'hF);
      flags(1'b1, 1'b1);
      put(4'hC);
      flags(1'b0, 1'b0);
      put(4'hF);
      outs(1'b1);
      // pulse scheme: a pulse still running decides nothing
      req_pulse();
      chk("busy", 1'b1, busy);
      chk("lock_request_a", 1'b1, u_link.lock_request_a);
      chk("lock_request_b", 1'b1, u_link.lock_request_b);
      repeat (100) @(negedge CLK);
      chk("lock_cmd", 1'b0, lock_cmd);
      // directional scheme: simultaneous edges are no command
      reboot(GLC_DIRECT);
      req_pulse();
      repeat (5) @(negedge CLK);
      chk("lock_cmd", 1'b0, lock_cmd);
      // non-directional scheme: simultaneous edges toggle the lock
      reboot(GLC_TOGGLE);
      req_pulse();
      repeat (5) @(negedge CLK);
      chk("lock_cmd", 1'b1, lock_cmd);
      stop_test();
   end
endmodule // testbench
